// *** src/stsb_cfg.svh ***
// Purpose: Constants for the symmetric skew buffer.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef STSB_CFG_SVH
`define STSB_CFG_SVH
`define STSB_DEPTH 16
`define STSB_AW 4
`define STSB_WIDTH 12
`define STSB_WIDTH_MIN 2
`define STSB_WIDTH_MAX 32
`define STSB_OFF_CTRL 32'h0000_0000
`define STSB_OFF_STAT 32'h0000_0004
`define STSB_OFF_DATA 32'h0000_0008
`define STSB_CTRL_RUN 0
`define STSB_CTRL_WE 1
`define STSB_CTRL_CRST 2
`define STSB_CTRL_RST 32'h0000_0003
`endif

// *** src/stsb_pkg.sv ***
// Purpose: Types shared by the skew buffer files.
// Assumes: Widths fixed by the configuration header.
// Notes: Holds types only.
`include "stsb_cfg.svh"
package stsb_pkg;
   typedef logic [`STSB_AW-1:0] stsb_addr_t;
   typedef logic [`STSB_WIDTH-1:0] stsb_word_t;
   typedef enum logic [1:0] {
      STSB_EMPTY = 2'b01,
      STSB_HOLD = 2'b10
   } stsb_st_t;
endpackage : stsb_pkg

// *** src/stsb_if.sv ***
// Purpose: Carries the sampled output word to the holding buffer.
// Assumes: One clock domain.
// Notes: Valid and ready handshake.
`timescale 1ns/1ps
interface stsb_if;
   logic valid;
   logic ready;
   stsb_pkg::stsb_word_t data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : stsb_if

// *** src/stsb_stage.sv ***
// Purpose: One 16-entry RAM stage with a registered output bit.
// Assumes: Shared address and enables from the top.
// Notes: Written synchronously, read asynchronously.
`timescale 1ns/1ps
`include "stsb_cfg.svh"
module stsb_stage (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Async reset, low.
   input wire logic ce, // Clock enable.
   input wire logic we, // Write enable.
   input wire stsb_pkg::stsb_addr_t addr, // Shared address.
   input wire logic din, // Stage input bit.
   output logic dout // Registered output bit.
);
   logic mem [`STSB_DEPTH];
   logic dout_q;
   logic dout_d;

   // The read is asynchronous, so the register isolates address ripple.
   always_comb begin
      dout_d = ce ? mem[addr] : dout_q; // see RQ10 see RQ15 see RQ16
   end

   // RAM has no reset; contents are undefined until written.
   always_ff @(posedge pclk) begin
      if (ce && we) begin
         mem[addr] <= din; // see RQ1 see RQ5 see RQ6
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_q <= 1'b0;
      end else begin
         dout_q <= dout_d;
      end
   end
   assign dout = dout_q;
endmodule : stsb_stage

// *** src/stsb_hold.sv ***
// Purpose: Two-entry buffer between output word and APB reader.
// Assumes: Source offers a word each enabled step.
// Notes: Back-pressure shows as ready low, stalling the buffer.
`timescale 1ns/1ps
module stsb_hold (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Async reset, low.
   stsb_if.dst in_p, // Filling side.
   output logic out_valid, // Word available.
   input wire logic out_ready, // Word consumed.
   output stsb_pkg::stsb_word_t out_data // Oldest word.
);
   stsb_pkg::stsb_word_t e0_q, e0_d, e1_q, e1_d;
   logic [1:0] cnt_q, cnt_d;
   logic push, pop;

   // Two entries, oldest in entry zero.
   always_comb begin
      push = in_p.valid && (cnt_q != 2'd2);
      pop = out_ready && (cnt_q != 2'd0);
      e0_d = e0_q;
      e1_d = e1_q;
      cnt_d = cnt_q;
      if (pop) begin
         e0_d = e1_q;
      end
      if (push) begin
         if ((cnt_q == 2'd0) || (cnt_q == 2'd1 && pop)) begin
            e0_d = in_p.data;
         end else begin
            e1_d = in_p.data;
         end
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         e0_q <= '0;
         e1_q <= '0;
         cnt_q <= 2'd0;
      end else begin
         e0_q <= e0_d;
         e1_q <= e1_d;
         cnt_q <= cnt_d;
      end
   end

   assign in_p.ready = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data = e0_q;
endmodule : stsb_hold

// *** src/stsb_top.sv ***
// Purpose: Symmetric 16-deep time skew buffer with APB control.
// Assumes: One clock; user logic also drives the pins directly.
// Notes: Rules follow; tags mark the logic that keeps each of them, except the user rules RQ2, RQ4 and RQ9.
// Overview of operation
// RQ1 - With write enable high, each RAM stores its input at counter address; here only with the WE control bit also set.
// RQ2 - User holds write enable low to keep a stored block intact.
// RQ3 - Clock enable high moves RAM data to outputs and advances counter; here only with RUN set and the snapshot buffer not full.
// RQ4 - User ties clock enable high when gating is not needed.
// RQ5 - One clock updates outputs, counter and RAM, only when enabled.
// RQ6 - Serial input is captured on an enabled rising edge.
// RQ7 - Upward input feeds bottom stage, downward input feeds top stage.
// RQ8 - Counter reset returns the address counter to zero next enabled edge.
// RQ9 - User raises counter reset at count N-2 for N-bit samples.
// RQ10 - Each output bit is a register of its RAM's read data.
// RQ11 - Number of stages is a build parameter from 2 to 32.
// RQ12 - Each stage holds 16 locations; counter spans at most 16.
// RQ13 - Counter runs from zero to a terminal value, then restarts.
// RQ14 - Each registered output feeds the next stage's RAM input.
// RQ15 - RAMs write synchronously and read asynchronously.
// RQ16 - With clock enable low, counter, outputs and RAM all hold.
// RQ17 - In read mode the counter advances and outputs show data.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "stsb_cfg.svh"
module stsb_top (
   input wire logic pclk, // Clock, 50 MHz.
   input wire logic presetn, // Async reset, low.
   input wire logic ce, // Clock enable pin.
   input wire logic we, // Write enable pin.
   input wire logic counter_reset, // Terminal count reset pin.
   input wire logic serial_in_upward, // Serial input, upward chain.
   input wire logic serial_in_downward, // Serial input, downward chain.
   output logic [`STSB_WIDTH-1:0] q_up, // Registered upward outputs.
   output logic [`STSB_WIDTH-1:0] q_down, // Registered downward outputs.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [31:0] paddr, // APB address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr // APB error.
);
   logic [31:0] ctrl_q, ctrl_d;
   stsb_pkg::stsb_addr_t address_counter_q, address_counter_d;
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;
   logic eff_ce, eff_we, eff_rst;
   logic hold_valid, hold_pop;
   stsb_pkg::stsb_word_t hold_data;
   logic [`STSB_WIDTH-1:0] up_in, dn_in;
   stsb_if cap ();

   ////////////////////////////////////////////////////////////////////////
   // Width must stay within the supported range.
   initial begin
      if (`STSB_WIDTH < `STSB_WIDTH_MIN || `STSB_WIDTH > `STSB_WIDTH_MAX)
      begin
         $error("Width out of range."); // see RQ11
      end
   end

   // Decodes an APB byte address into a register hit.
   function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
      hit = (a == o);
   endfunction : hit

   // True for any of the three mapped register offsets.
   function automatic logic mapped(input logic [31:0] a);
      mapped = hit(a, `STSB_OFF_CTRL) || hit(a, `STSB_OFF_STAT) ||
         hit(a, `STSB_OFF_DATA);
   endfunction : mapped

   // Software may also gate the buffer; the snapshot buffer stalls it when
   // full so no sampled word is lost.
   always_comb begin
      eff_ce = ce && ctrl_q[`STSB_CTRL_RUN] && cap.ready; // see RQ3
      eff_we = we && ctrl_q[`STSB_CTRL_WE];
      eff_rst = counter_reset || ctrl_q[`STSB_CTRL_CRST];
   end

   ////////////////////////////////////////////////////////////////////////
   // Address counter: wraps to zero on reset at the terminal count.
   always_comb begin
      address_counter_d = address_counter_q; // see RQ16
      if (eff_ce) begin
         if (eff_rst) begin
            address_counter_d = '0; // see RQ8 see RQ13
         end else begin
            address_counter_d = address_counter_q + 4'h1; // see RQ12 RQ17
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         address_counter_q <= '0;
      end else begin
         address_counter_q <= address_counter_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two chains; each output feeds the next stage in its direction.
   assign up_in = {q_up[`STSB_WIDTH-2:0], serial_in_upward}; // see RQ7
   assign dn_in = {serial_in_downward, q_down[`STSB_WIDTH-1:1]}; // see RQ14

   genvar gi;
   generate
      for (gi = 0; gi < `STSB_WIDTH; gi++) begin : g_stage
         stsb_stage u_up (
            .pclk(pclk),
            .presetn(presetn),
            .ce(eff_ce),
            .we(eff_we),
            .addr(address_counter_q),
            .din(up_in[gi]),
            .dout(q_up[gi])
         );
         stsb_stage u_dn (
            .pclk(pclk),
            .presetn(presetn),
            .ce(eff_ce),
            .we(eff_we),
            .addr(address_counter_q),
            .din(dn_in[gi]),
            .dout(q_down[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Each enabled step offers the upward word to the snapshot buffer.
   assign cap.valid = eff_ce;
   assign cap.data = q_up;

   stsb_hold u_hold (
      .pclk(pclk),
      .presetn(presetn),
      .in_p(cap.dst),
      .out_valid(hold_valid),
      .out_ready(hold_pop),
      .out_data(hold_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, unmapped addresses return an error.
   always_comb begin
      ctrl_d = ctrl_q;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      hold_pop = 1'b0;
      if (psel && !penable) begin
         if (hit(paddr, `STSB_OFF_CTRL)) begin
            prdata_d = ctrl_q;
         end else if (hit(paddr, `STSB_OFF_STAT)) begin
            prdata_d = {23'h00_0000, hold_valid, 4'h0, address_counter_q};
         end else if (hit(paddr, `STSB_OFF_DATA)) begin
            prdata_d = {{(32-`STSB_WIDTH){1'b0}}, hold_data};
         end else begin
            prdata_d = 32'h0000_0000;
            pslverr_d = 1'b1;
         end
      end else if (psel && penable) begin
         pslverr_d = pslverr_q;
         if (pwrite && hit(paddr, `STSB_OFF_CTRL)) begin
            ctrl_d = {29'h0000_0000, pwdata[2:0]};
         end
         if (!pwrite && hit(paddr, `STSB_OFF_DATA)) begin
            hold_pop = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `STSB_CTRL_RST;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q && psel && penable;

   ////////////////////////////////////////////////////////////////////////
   // Checker shadow. It remembers the first address written after reset
   // and the bits that entered both entry stages there; a later write to
   // that address refreshes them. Reading the address back is then judged
   // in one cycle instead of unrolling a long chain of enabled steps.
   // Only one address is followed, so other locations go unjudged here.
   logic probe_arm_q, probe_arm_d;
   stsb_pkg::stsb_addr_t probe_addr_q, probe_addr_d;
   logic probe_up_q, probe_up_d;
   logic probe_dn_q, probe_dn_d;

   // Arm on the first write; refresh on writes to the followed address.
   always_comb begin
      probe_arm_d = probe_arm_q;
      probe_addr_d = probe_addr_q;
      probe_up_d = probe_up_q;
      probe_dn_d = probe_dn_q;
      if (eff_ce && eff_we) begin
         if (!probe_arm_q || address_counter_q == probe_addr_q) begin
            probe_arm_d = 1'b1;
            probe_addr_d = address_counter_q;
            probe_up_d = serial_in_upward;
            probe_dn_d = serial_in_downward;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         probe_arm_q <= 1'b0;
         probe_addr_q <= '0;
         probe_up_q <= 1'b0;
         probe_dn_q <= 1'b0;
      end else begin
         probe_arm_q <= probe_arm_d;
         probe_addr_q <= probe_addr_d;
         probe_up_q <= probe_up_d;
         probe_dn_q <= probe_dn_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_hold_count;
      @(posedge pclk) disable iff (!presetn)
      !eff_ce |=> $stable(address_counter_q);
   endproperty
   a_hold_count: assert property (p_hold_count) // see RQ16
      else $error("Counter moved while disabled.");

   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
      eff_ce && eff_rst |=> address_counter_q == 4'h0;
   endproperty
   a_wrap: assert property (p_wrap) // see RQ8
      else $error("Counter did not return to zero.");

   property p_step;
      @(posedge pclk) disable iff (!presetn)
      eff_ce && !eff_rst |=>
         address_counter_q == $past(address_counter_q) + 4'h1;
   endproperty
   a_step: assert property (p_step) // see RQ17
      else $error("Counter did not advance.");

   property p_out_hold;
      @(posedge pclk) disable iff (!presetn)
      !eff_ce |=> $stable(q_up) && $stable(q_down);
   endproperty
   a_out_hold: assert property (p_out_hold) // see RQ5
      else $error("Outputs moved while disabled.");

   // The entry stages must give back what was last stored at an address.
   property p_first_up;
      @(posedge pclk) disable iff (!presetn)
      eff_ce && probe_arm_q && (address_counter_q == probe_addr_q) |=>
         q_up[0] == $past(probe_up_q);
   endproperty
   a_first_up: assert property (p_first_up) // see RQ1 see RQ6
      else $error("Upward entry stage lost its stored bit.");

   property p_first_dn;
      @(posedge pclk) disable iff (!presetn)
      eff_ce && probe_arm_q && (address_counter_q == probe_addr_q) |=>
         q_down[`STSB_WIDTH-1] == $past(probe_dn_q);
   endproperty
   a_first_dn: assert property (p_first_dn) // see RQ7 see RQ10
      else $error("Downward entry stage lost its stored bit.");

   property p_wrap_top;
      @(posedge pclk) disable iff (!presetn)
      eff_ce && !eff_rst && address_counter_q == 4'hF |=>
         address_counter_q == 4'h0;
   endproperty
   a_wrap_top: assert property (p_wrap_top) // see RQ12
      else $error("Counter did not wrap after sixteen locations.");

   // Bus checks: refused accesses and control writes.
   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !mapped(paddr) ##1 psel && penable |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("Unmapped access was not refused.");

   property p_ctrl_write;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && hit(paddr, `STSB_OFF_CTRL) |=>
         ctrl_q == {29'h0000_0000, $past(pwdata[2:0])};
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("Control write did not land.");
endmodule : stsb_top

// *** bench/stsb_partner.sv ***
// Purpose: Stands in for the user logic around the skew buffer.
// Assumes: The bench holds go high for one clock per enabled step it wants.
// Notes: Serial bits and write enable are random from a fixed seed.
`timescale 1ns/1ps
module stsb_partner #(parameter int LEN = 12) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Sync reset, low.
   input wire logic go, // Request one enabled step.
   output logic ce, // Clock enable pin.
   output logic we, // Write enable pin.
   output logic counter_reset, // Terminal count reset pin.
   output logic sin_up, // Upward serial bit.
   output logic sin_dn // Downward serial bit.
);
   int seed = 32'hae5e;
   logic [31:0] r;
   logic [3:0] cnt_q;
   initial begin
      {ce, we, counter_reset, sin_up, sin_dn} = 5'h00;
      cnt_q = 4'h0;
   end
   // Write enable and data also move while ce is low, so holding is seen.
   always @(posedge pclk) begin
      r = $random(seed);
      ce <= go;
      we <= r[0];
      sin_up <= r[1];
      sin_dn <= r[2];
      counter_reset <= go && (cnt_q == 4'(LEN - 2));
      if (!presetn) begin
         cnt_q <= 4'h0;
      end else if (ce) begin
         cnt_q <= counter_reset ? 4'h0 : cnt_q + 4'h1;
      end
   end
endmodule : stsb_partner

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the skew buffer.
// Assumes: The snapshot buffer is drained after every burst of steps.
// Notes: Snapshot words, status, pins and the counter are all judged.
`timescale 1ns/1ps
`include "stsb_cfg.svh"
module tb_top;
   localparam int W = `STSB_WIDTH;
   logic pclk = 1'b0;
   logic presetn, go, psel, penable, pwrite;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic pready, pslverr, ce, we, counter_reset, sin_up, sin_dn, er;
   logic [W-1:0] q_up, q_down, qu_m, qd_m, nu, nd;
   logic mu [W][16];
   logic md [W][16];
   logic [3:0] cnt_m;
   logic [W-1:0] hq [$];
   logic [2:0] ctrl_m = 3'h3;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [2:0] phase [6] = '{3'h3, 3'h1, 3'h7, 3'h0, 3'h3, 3'h2};
   always #10 pclk = ~pclk;
   stsb_partner #(.LEN(12)) u_partner (.pclk(pclk), .presetn(presetn),
      .go(go), .ce(ce), .we(we), .counter_reset(counter_reset),
      .sin_up(sin_up), .sin_dn(sin_dn));
   stsb_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .we(we),
      .counter_reset(counter_reset), .serial_in_upward(sin_up),
      .serial_in_downward(sin_dn), .q_up(q_up), .q_down(q_down),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   ////////////////////////////////////////////////////////////////////
   // Reference model: reads old RAM data, then writes, then steps. The
   // snapshot buffer holds two words; when full it stalls every step.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_m = 4'h0;
         qu_m = '0;
         qd_m = '0;
      end else if (ce && ctrl_m[0] && hq.size() < 2) begin
         hq.push_back(qu_m);
         for (int k = 0; k < W; k++) begin
            nu[k] = mu[k][cnt_m];
            nd[k] = md[k][cnt_m];
            if (we && ctrl_m[1]) begin
               mu[k][cnt_m] = (k == 0) ? sin_up : qu_m[k-1];
               md[k][cnt_m] = (k == W - 1) ? sin_dn : qd_m[k+1];
            end
         end
         qu_m = nu;
         qd_m = nd;
         cnt_m = (counter_reset || ctrl_m[2]) ? 4'h0 : cnt_m + 4'h1;
      end
   end
   // A hang ends the run as a failure.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (n_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [31:0] e, g);
      num_checks++;
      if (e !== g) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Bits whose model value is still unknown are skipped.
   task automatic cmpq(input string n, input logic [W-1:0] e, g);
      for (int k = 0; k < W; k++) begin
         if (e[k] !== 1'bx) begin
            chk(n, {31'h0, e[k]}, {31'h0, g[k]});
         end
      end
   endtask : cmpq
   // One APB transfer; request is held until pready is seen high.
   task automatic apb(input logic wr, input logic [31:0] a, wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Clock enable held for len clocks, then status, snapshots and pins.
   task automatic step(input int len);
      @(posedge pclk);
      go <= 1'b1;
      repeat (len) @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      apb(1'b0, `STSB_OFF_STAT, 32'h0000_0000);
      chk("count", {28'h0, cnt_m}, {28'h0, rd[3:0]});
      chk("snap_valid", {31'h0, hq.size() != 0}, {31'h0, rd[8]});
      while (hq.size() > 0) begin
         apb(1'b0, `STSB_OFF_DATA, 32'h0000_0000);
         chk("snap_high", 32'h0000_0000, rd >> W);
         cmpq("snap_data", hq.pop_front(), rd[W-1:0]);
      end
      cmpq("q_up", qu_m, q_up);
      cmpq("q_down", qd_m, q_down);
   endtask : step
   ////////////////////////////////////////////////////////////////////
   initial begin
      {presetn, go, psel, penable, pwrite} = 5'h00;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("q_up", 32'h0000_0000, {20'h0, q_up});
      chk("q_down", 32'h0000_0000, {20'h0, q_down});
      apb(1'b0, `STSB_OFF_CTRL, 32'h0000_0000);
      chk("ctrl", 32'h0000_0003, rd);
      apb(1'b0, 32'h0000_000C, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, {31'h0, er});
      chk("prdata", 32'h0000_0000, rd);
      for (int p = 0; p < 6; p++) begin
         apb(1'b1, `STSB_OFF_CTRL, {29'h0, phase[p]});
         ctrl_m = phase[p];
         apb(1'b0, `STSB_OFF_CTRL, 32'h0000_0000);
         chk("ctrl", {29'h0, phase[p]}, rd);
         repeat ((p == 0) ? 120 : 40) step(1);
         step(6);
      end
      report_and_stop();
   end
endmodule : tb_top
